//--- verilog/fwp_pkg.sv
// Package of constants for the flash array write-protection block.
// Assumes a 22-bit byte address and a command decoder outside this block.
package fwp_pkg;
  // ----------------------------------------------------------------------
  // Array organisation
  // ----------------------------------------------------------------------
  localparam int unsigned ARRAY_BYTES    = 4194304;
  localparam int unsigned SECTOR_COUNT   = 64;
  localparam int unsigned SUBSECTOR_CNT  = 1024;
  localparam int unsigned PAGE_COUNT     = 16384;
  localparam int unsigned OTP_BYTES      = 64;
  localparam int unsigned ADDR_W         = 22;
  localparam int unsigned SECT_W         = 6;
  localparam int unsigned SUBS_W         = 10;
  localparam int unsigned PAGE_W         = 14;
  localparam int unsigned OTP_W          = 6;
  localparam int unsigned SECT_LSB       = 16;
  localparam int unsigned SUBS_LSB       = 12;
  localparam int unsigned PAGE_LSB       = 8;
  localparam int unsigned ADDR_MSB       = 21;
  // ----------------------------------------------------------------------
  // Lock register and flag layout
  // ----------------------------------------------------------------------
  localparam int unsigned LOCK_WRITE_BIT = 0;
  localparam int unsigned LOCK_DOWN_BIT  = 1;
  localparam logic [1:0]  LOCK_RESET     = 2'h0;
  localparam int unsigned FLAG_PROT_BIT  = 1;
  localparam logic [2:0]  RANGE_NONE     = 3'h0;
  localparam logic [2:0]  RANGE_ALL      = 3'h7;

  // Operation codes presented by the command decoder.
  typedef enum logic [2:0] {
    FWP_OP_NONE    = 3'b000,
    FWP_OP_PROGRAM = 3'b001,
    FWP_OP_SUBERASE= 3'b010,
    FWP_OP_SECERASE= 3'b011,
    FWP_OP_BULK    = 3'b100,
    FWP_OP_OTPPROG = 3'b101
  } fwp_op_t;
endpackage

//--- verilog/fwp_range_if.sv
// Interface between the protection core and the range decoder.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface fwp_range_if;
  logic [2:0] rangeSel;
  logic       rangeDir;
  logic [5:0] sector;
  logic       inRange;
  modport core (output rangeSel, output rangeDir, output sector, input inRange);
  modport dec  (input rangeSel, input rangeDir, input sector, output inRange);
endinterface

//--- verilog/fwp_range_decode.sv
// Block-range decoder: tells whether a sector lies in the read-only region.
// Purely combinational; the core registers its result.
`timescale 1ns/1ps
module fwp_range_decode (
  fwp_range_if.dec rng
);
  wire [6:0] protCount;
  wire [6:0] sectorExt;
  wire [6:0] topFirst;

  // Code n (1..6) protects 2^(n-1) sectors; code 7 protects all of them.
  assign protCount = (rng.rangeSel == fwp_pkg::RANGE_NONE) ? 7'h00 :
                     (rng.rangeSel == fwp_pkg::RANGE_ALL)  ? 7'h40 :
                     (7'h01 << (rng.rangeSel - 3'h1));
  assign sectorExt = {1'b0, rng.sector};
  assign topFirst  = 7'h40 - protCount;
  assign rng.inRange = rng.rangeDir ? (sectorExt < protCount)
                                    : (sectorExt >= topFirst) && (protCount != 7'h00);
endmodule // fwp_range_decode

//--- verilog/fwp_protect.sv
// Write-protection core of a serial flash array: lock registers, range bits,
// freeze logic and the protection-error flag.
// Assumes a command decoder on ref_clk presents one-cycle strobes; wgPin is async.
`timescale 1ns/1ps
// Behaviour
// - Each of the 64 sectors owns a lock register with a write-lock and a lock-down bit.
// - The read-lock and write-lock commands reach the lock register of any sector.
// - A set write-lock bit makes program and erase of the sector fail untouched.
// - A set lock-down bit freezes both lock bits of the sector until the next power-up.
// - A sector is protected when either the lock scheme or the range scheme protects it.
// - The read-only region comes from the three range bits and the direction bit.
// - With direction zero, codes one to seven protect the top 1,2,4,8,16,32 or all sectors.
// - With direction one, codes one to seven protect the bottom 1,2,4,8,16,32 or all sectors.
// - With the guard pin low and the freeze bit set, range and freeze bits cannot change.
// - The array is 4 Mbyte in 64 sectors, 1,024 subsectors and 16,384 pages.
// - A 64-byte one-time-programmable area sits outside the main array.
// - Pages program alone and programming only clears bits.
// - Erase works by subsector, sector or whole array, never by page, and sets bits.
// - A denied operation or a frozen status write sets the protection flag until a clear-flags command; a refused lock write does not.
module fwp_protect (
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  input  wire logic                    wgPinN,
  input  wire logic                    opValid,
  input  wire fwp_pkg::fwp_op_t        opCode,
  input  wire logic [21:0]             opAddr,
  input  wire logic                    otpLocked,
  input  wire logic                    lockRdValid,
  input  wire logic                    lockWrValid,
  input  wire logic [21:0]             lockAddr,
  input  wire logic [1:0]              lockWrData,
  input  wire logic                    statusWrValid,
  input  wire logic [2:0]              statusWrRange,
  input  wire logic                    statusWrDir,
  input  wire logic                    statusWrFreeze,
  input  wire logic                    clearFlags,
  output logic                         opGrant,
  output logic                         opDeny,
  output logic [5:0]                   opSector,
  output logic [9:0]                   opSubsector,
  output logic [13:0]                  opPage,
  output logic [5:0]                   opOtpIndex,
  output logic                         opEraseFill,
  output logic                         opSectorMask,
  output logic                         lockRdReady,
  output logic [1:0]                   lockRdData,
  output logic [2:0]                   rangeSelOut,
  output logic                         rangeDirOut,
  output logic                         freezeOut,
  output logic                         protErr
);
  // ----------------------------------------------------------------------
  // Guard pin synchroniser
  // ----------------------------------------------------------------------
  logic wgMeta_q;
  logic wgSync_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wgMeta_q <= 1'b1;
      wgSync_q <= 1'b1;
    end else begin
      wgMeta_q <= wgPinN;
      wgSync_q <= wgMeta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Lock registers
  // ----------------------------------------------------------------------
  // Volatile state: only the reset (power-up) releases a lock-down.
  logic [1:0] lock_q [fwp_pkg::SECTOR_COUNT];
  wire  [5:0] lockSector = lockAddr[fwp_pkg::ADDR_MSB:fwp_pkg::SECT_LSB];
  wire  [1:0] lockSel    = lock_q[lockSector];
  wire        lockWrOk   = lockWrValid && !lockSel[fwp_pkg::LOCK_DOWN_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < fwp_pkg::SECTOR_COUNT; gi++) begin : g_lock
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          lock_q[gi] <= fwp_pkg::LOCK_RESET;
        end else if (lockWrOk && (lockSector == 6'(gi))) begin
          lock_q[gi] <= lockWrData;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lockRdReady <= 1'b0;
      lockRdData  <= 2'h0;
    end else begin
      lockRdReady <= lockRdValid;
      if (lockRdValid) begin
        lockRdData <= lockSel;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status range and freeze bits
  // ----------------------------------------------------------------------
  logic [2:0] range_q;
  logic       dir_q;
  logic       freeze_q;
  wire        statusFrozen = freeze_q && !wgSync_q;
  wire        statusWrOk   = statusWrValid && !statusFrozen;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      range_q  <= fwp_pkg::RANGE_NONE;
      dir_q    <= 1'b0;
      freeze_q <= 1'b0;
    end else if (statusWrOk) begin
      range_q  <= statusWrRange;
      dir_q    <= statusWrDir;
      freeze_q <= statusWrFreeze;
    end
  end
  assign rangeSelOut = range_q;
  assign rangeDirOut = dir_q;
  assign freezeOut   = freeze_q;

  // ----------------------------------------------------------------------
  // Operation check
  // ----------------------------------------------------------------------
  fwp_range_if rng ();
  fwp_range_decode u_range (
    .rng (rng)
  );

  wire [5:0]  curSector = opAddr[fwp_pkg::ADDR_MSB:fwp_pkg::SECT_LSB];
  wire [9:0]  curSubs   = opAddr[fwp_pkg::ADDR_MSB:fwp_pkg::SUBS_LSB];
  wire [13:0] curPage   = opAddr[fwp_pkg::ADDR_MSB:fwp_pkg::PAGE_LSB];
  assign rng.rangeSel = range_q;
  assign rng.rangeDir = dir_q;
  assign rng.sector   = curSector;

  // Bulk erase is refused when any sector is protected, by either scheme.
  logic [63:0] sectLockVec;
  always_comb begin
    for (int i = 0; i < fwp_pkg::SECTOR_COUNT; i++) begin
      sectLockVec[i] = lock_q[i][fwp_pkg::LOCK_WRITE_BIT];
    end
  end
  wire anyLocked   = |sectLockVec;
  wire anyRange    = (range_q != fwp_pkg::RANGE_NONE);
  wire isOtp       = (opCode == fwp_pkg::FWP_OP_OTPPROG);
  wire isBulk      = (opCode == fwp_pkg::FWP_OP_BULK);
  wire isErase     = isBulk || (opCode == fwp_pkg::FWP_OP_SUBERASE) ||
                     (opCode == fwp_pkg::FWP_OP_SECERASE);
  wire isModify    = (opCode != fwp_pkg::FWP_OP_NONE);
  wire sectProt    = lock_q[curSector][fwp_pkg::LOCK_WRITE_BIT] || rng.inRange;
  wire opBlocked   = isOtp  ? otpLocked :
                     isBulk ? (anyLocked || anyRange) : sectProt;
  wire opFire      = opValid && isModify;
  wire statusViol  = statusWrValid && statusFrozen;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      opGrant      <= 1'b0;
      opDeny       <= 1'b0;
      opSector     <= 6'h00;
      opSubsector  <= 10'h000;
      opPage       <= 14'h0000;
      opOtpIndex   <= 6'h00;
      opEraseFill  <= 1'b0;
      opSectorMask <= 1'b0;
    end else begin
      opGrant <= opFire && !opBlocked;
      opDeny  <= opFire && opBlocked;
      if (opFire) begin
        opSector     <= curSector;
        opSubsector  <= curSubs;
        opPage       <= curPage;
        opOtpIndex   <= opAddr[fwp_pkg::OTP_W-1:0];
        opEraseFill  <= isErase;
        opSectorMask <= (opCode == fwp_pkg::FWP_OP_SECERASE);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Protection error flag
  // ----------------------------------------------------------------------
  // A violation in the same cycle as a clear keeps the flag set.
  wire protSet = (opFire && opBlocked) || statusViol;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      protErr <= 1'b0;
    end else if (protSet) begin
      protErr <= 1'b1;
    end else if (clearFlags) begin
      protErr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_locked_denied: assert property (@(posedge ref_clk) disable iff (!rstn)
    opFire && !isOtp && lock_q[curSector][fwp_pkg::LOCK_WRITE_BIT] |=> opDeny && !opGrant)
    else $error("locked sector was granted");
  a_lockdown_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
    lockWrValid && lockSel[fwp_pkg::LOCK_DOWN_BIT] |=> lock_q[$past(lockSector)] == $past(lockSel))
    else $error("locked-down register changed");
  a_lock_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    lockWrValid && !lockSel[fwp_pkg::LOCK_DOWN_BIT] |=> lock_q[$past(lockSector)] == $past(lockWrData))
    else $error("lock write not stored");
  a_lock_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    lockRdValid |=> lockRdReady && lockRdData == $past(lockSel))
    else $error("lock read wrong");
  a_range_denied: assert property (@(posedge ref_clk) disable iff (!rstn)
    opFire && !isOtp && rng.inRange |=> opDeny)
    else $error("range-protected sector granted");
  a_top_one: assert property (@(posedge ref_clk) disable iff (!rstn)
    range_q == 3'h1 && !dir_q |-> rng.inRange == (curSector == 6'h3f))
    else $error("top range code one wrong");
  a_bottom_half: assert property (@(posedge ref_clk) disable iff (!rstn)
    range_q == 3'h6 && dir_q |-> rng.inRange == (curSector < 6'h20))
    else $error("bottom half range wrong");
  a_freeze_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
    statusWrValid && statusFrozen |=> $stable(range_q) && $stable(freeze_q) && protErr)
    else $error("frozen status changed");
  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rstn)
    protErr && !clearFlags |=> protErr)
    else $error("protection flag dropped without clear");
  a_flag_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    opFire && opBlocked && clearFlags |=> protErr)
    else $error("protection flag lost");
endmodule // fwp_protect

//--- test/fwp_host_model.sv
// Partner model: the command decoder that strobes requests into the protection core.
// Assumes one ref_clk domain; every request rises at a falling edge and lasts one cycle.
`timescale 1ns/1ps
module fwp_host_model (
  input  wire logic         ref_clk,
  output logic              opValid,
  output fwp_pkg::fwp_op_t  opCode,
  output logic [21:0]       opAddr,
  output logic              lockRdValid,
  output logic              lockWrValid,
  output logic [21:0]       lockAddr,
  output logic [1:0]        lockWrData,
  output logic              statusWrValid,
  output logic [2:0]        statusWrRange,
  output logic              statusWrDir,
  output logic              statusWrFreeze,
  output logic              clearFlags
);
  initial begin
    {opValid, lockRdValid, lockWrValid, statusWrValid, clearFlags} = 5'h00;
    opCode = fwp_pkg::FWP_OP_NONE;
    {opAddr, lockAddr, lockWrData} = 46'h0;
    {statusWrRange, statusWrDir, statusWrFreeze} = 5'h00;
  end
  // Released qualifiers are inverted so the core cannot lean on a stale value.
  task automatic op(input fwp_pkg::fwp_op_t c, input logic [21:0] a);
    @(negedge ref_clk);
    opCode = c;
    opAddr = a;
    opValid = 1'b1;
    @(negedge ref_clk);
    opValid = 1'b0;
    opAddr = ~a;
  endtask
  // Read and write of a sector lock register may share one strobe cycle.
  task automatic lockCmd(input logic rd, input logic wr, input logic [21:0] a,
                         input logic [1:0] v);
    @(negedge ref_clk);
    lockAddr = a;
    lockWrData = v;
    lockRdValid = rd;
    lockWrValid = wr;
    @(negedge ref_clk);
    {lockRdValid, lockWrValid} = 2'h0;
    lockAddr = ~a;
    lockWrData = ~v;
  endtask
  task automatic statusWr(input logic [2:0] r, input logic d, input logic f);
    @(negedge ref_clk);
    {statusWrRange, statusWrDir, statusWrFreeze} = {r, d, f};
    statusWrValid = 1'b1;
    @(negedge ref_clk);
    statusWrValid = 1'b0;
    {statusWrRange, statusWrDir, statusWrFreeze} = ~{r, d, f};
  endtask
  task automatic clr;
    @(negedge ref_clk);
    clearFlags = 1'b1;
    @(negedge ref_clk);
    clearFlags = 1'b0;
  endtask
endmodule // fwp_host_model

//--- test/tb_flash_array_write_protection.sv
// Self-checking bench for the write-protection core, driven through the host model.
// Assumes inputs change on the falling edge and registered answers stand for one cycle.
`timescale 1ns/1ps
module tb_flash_array_write_protection;
  logic              ref_clk, rstn, wgPinN, otpLocked, opValid, lockRdValid, lockWrValid;
  logic              statusWrValid, statusWrDir, statusWrFreeze, clearFlags;
  fwp_pkg::fwp_op_t  opCode;
  logic [21:0]       opAddr, lockAddr;
  logic [1:0]        lockWrData, lockRdData;
  logic [2:0]        statusWrRange, rangeSelOut;
  logic              opGrant, opDeny, opEraseFill, opSectorMask, lockRdReady;
  logic              rangeDirOut, freezeOut, protErr;
  logic [5:0]        opSector, opOtpIndex;
  logic [9:0]        opSubsector;
  logic [13:0]       opPage;
  int                fails = 0, totalChecks = 0, cycles = 0;

  fwp_host_model host (.ref_clk(ref_clk), .opValid(opValid), .opCode(opCode),
    .opAddr(opAddr), .lockRdValid(lockRdValid), .lockWrValid(lockWrValid),
    .lockAddr(lockAddr), .lockWrData(lockWrData), .statusWrValid(statusWrValid),
    .statusWrRange(statusWrRange), .statusWrDir(statusWrDir),
    .statusWrFreeze(statusWrFreeze), .clearFlags(clearFlags));
  fwp_protect uut (.ref_clk(ref_clk), .rstn(rstn), .wgPinN(wgPinN), .opValid(opValid),
    .opCode(opCode), .opAddr(opAddr), .otpLocked(otpLocked), .lockRdValid(lockRdValid),
    .lockWrValid(lockWrValid), .lockAddr(lockAddr), .lockWrData(lockWrData),
    .statusWrValid(statusWrValid), .statusWrRange(statusWrRange),
    .statusWrDir(statusWrDir), .statusWrFreeze(statusWrFreeze), .clearFlags(clearFlags),
    .opGrant(opGrant), .opDeny(opDeny), .opSector(opSector), .opSubsector(opSubsector),
    .opPage(opPage), .opOtpIndex(opOtpIndex), .opEraseFill(opEraseFill),
    .opSectorMask(opSectorMask), .lockRdReady(lockRdReady), .lockRdData(lockRdData),
    .rangeSelOut(rangeSelOut), .rangeDirOut(rangeDirOut), .freezeOut(freezeOut),
    .protErr(protErr));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // The whole run needs well under a thousand cycles; a hang is cut at five thousand.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end

  task automatic chkVec(input logic [31:0] a, input logic [31:0] e);
    totalChecks++;
    if (a !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic tryOp(input fwp_pkg::fwp_op_t c, input logic [21:0] a, input logic deny);
    host.op(c, a);
    chkVec({opGrant, opDeny}, {~deny, deny});
    chkVec(protErr, deny);
    host.clr();
    chkVec(protErr, 1'b0);
  endtask
  task automatic scnLocks;
    chkVec({opGrant, opDeny, protErr, rangeSelOut, rangeDirOut, freezeOut}, 0);
    host.lockCmd(1'b0, 1'b1, 22'h050000, 2'h1);
    host.lockCmd(1'b1, 1'b0, 22'h05ffff, 2'h0);
    chkVec({lockRdReady, lockRdData}, 3'h5);
    tryOp(fwp_pkg::FWP_OP_PROGRAM, 22'h051234, 1'b1);
    host.lockCmd(1'b1, 1'b1, 22'h050000, 2'h0);
    chkVec({lockRdReady, lockRdData}, 3'h5);
    tryOp(fwp_pkg::FWP_OP_SUBERASE, 22'h05f000, 1'b0);
    host.lockCmd(1'b0, 1'b1, 22'h090000, 2'h3);
    host.lockCmd(1'b0, 1'b1, 22'h090000, 2'h0);
    host.lockCmd(1'b1, 1'b0, 22'h090000, 2'h0);
    chkVec({lockRdReady, lockRdData}, 3'h7);
    tryOp(fwp_pkg::FWP_OP_SECERASE, 22'h09a000, 1'b1);
  endtask
  task automatic scnFields;
    tryOp(fwp_pkg::FWP_OP_PROGRAM, 22'h2ab3c4, 1'b0);
    chkVec({opSector, opSubsector, opPage}, {6'h2a, 10'h2ab, 14'h2ab3});
    chkVec({opEraseFill, opSectorMask}, 2'h0);
    tryOp(fwp_pkg::FWP_OP_SUBERASE, 22'h3ff000, 1'b0);
    chkVec({opEraseFill, opSectorMask, opSubsector}, {2'h2, 10'h3ff});
    tryOp(fwp_pkg::FWP_OP_SECERASE, 22'h000000, 1'b0);
    chkVec({opEraseFill, opSectorMask}, 2'h3);
    tryOp(fwp_pkg::FWP_OP_BULK, 22'h000000, 1'b1);
    tryOp(fwp_pkg::FWP_OP_OTPPROG, 22'h00002d, 1'b0);
    chkVec(opOtpIndex, 6'h2d);
    otpLocked = 1'b1;
    tryOp(fwp_pkg::FWP_OP_OTPPROG, 22'h000011, 1'b1);
    // A violation and a clear in the same cycle must leave the flag set.
    fork
      host.op(fwp_pkg::FWP_OP_OTPPROG, 22'h000011);
      host.clr();
    join
    chkVec({opDeny, protErr}, 2'h3);
    host.clr();
    chkVec(protErr, 1'b0);
  endtask
  task automatic scnRange;
    int n, s;
    for (int d = 0; d < 2; d++) begin
      for (int c = 0; c < 8; c++) begin
        n = (c == 7) ? 64 : ((c == 0) ? 0 : (1 << (c - 1)));
        host.statusWr(c[2:0], d[0], 1'b0);
        chkVec({rangeSelOut, rangeDirOut}, {c[2:0], d[0]});
        s = (d == 1) ? n - 1 : 64 - n;
        if (n > 0) tryOp(fwp_pkg::FWP_OP_PROGRAM, {s[5:0], 16'h0}, 1'b1);
        s = (d == 1) ? n : 63 - n;
        if (n < 64) tryOp(fwp_pkg::FWP_OP_PROGRAM, {s[5:0], 16'hffff}, 1'b0);
      end
    end
  endtask
  task automatic scnFreeze;
    wgPinN = 1'b0;
    host.statusWr(3'h3, 1'b1, 1'b1);
    chkVec({rangeSelOut, rangeDirOut, freezeOut}, 5'h0f);
    host.statusWr(3'h0, 1'b0, 1'b0);
    chkVec({rangeSelOut, rangeDirOut, freezeOut, protErr}, 6'h1f);
    host.clr();
    wgPinN = 1'b1;
    // The guard pin reaches the core through two flip-flops.
    repeat (2) @(negedge ref_clk);
    host.statusWr(3'h0, 1'b0, 1'b0);
    chkVec({rangeSelOut, rangeDirOut, freezeOut, protErr}, 6'h00);
  endtask
  task automatic scnPowerUp;
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    chkVec({protErr, rangeSelOut, rangeDirOut, freezeOut}, 0);
    host.lockCmd(1'b1, 1'b0, 22'h090000, 2'h0);
    chkVec({lockRdReady, lockRdData}, 3'h4);
    tryOp(fwp_pkg::FWP_OP_SECERASE, 22'h09a000, 1'b0);
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    {rstn, otpLocked} = 2'h0;
    wgPinN = 1'b1;
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    scnLocks();
    scnFields();
    otpLocked = 1'b0;
    scnRange();
    scnFreeze();
    scnPowerUp();
    complete_run();
  end
endmodule // tb_flash_array_write_protection
